// *** fmsu_pkg.sv ***
// Constants, register map and types for the float multiply and split unit
package fmsu_pkg;

   // Register byte addresses
   localparam logic [7:0] FMSU_ADDR_MODE = 8'h00;
   localparam logic [7:0] FMSU_ADDR_CMD = 8'h04;
   localparam logic [7:0] FMSU_ADDR_SRC_HI = 8'h08;
   localparam logic [7:0] FMSU_ADDR_SRC_LO = 8'h0C;
   localparam logic [7:0] FMSU_ADDR_STATUS = 8'h10;
   localparam logic [7:0] FMSU_ADDR_ACC_BASE = 8'h20;
   localparam logic [7:0] FMSU_ADDR_ACC_LAST = 8'h3C;

   // Mode register fields
   localparam int FMSU_MODE_PRECISION = 0;
   localparam int FMSU_MODE_CHOP = 1;
   localparam int FMSU_MODE_OVF_TE = 2;
   localparam int FMSU_MODE_UNF_TE = 3;
   localparam int FMSU_MODE_UV_TE = 4;
   localparam int FMSU_MODE_W = 5;
   localparam logic [FMSU_MODE_W-1:0] FMSU_MODE_RESET = 5'h00;

   // Command register fields
   localparam int FMSU_CMD_DEST_LSB = 0;
   localparam int FMSU_CMD_SPLIT = 2;
   localparam int FMSU_CMD_W = 3;

   // Status register fields
   localparam int FMSU_ST_DONE = 0;
   localparam int FMSU_ST_CARRY = 1;
   localparam int FMSU_ST_OVF = 2;
   localparam int FMSU_ST_ZERO = 3;
   localparam int FMSU_ST_NEG = 4;
   localparam int FMSU_ST_TRAP_UV = 5;
   localparam int FMSU_ST_TRAP_OVF = 6;
   localparam int FMSU_ST_TRAP_UNF = 7;
   localparam int FMSU_ST_W = 8;

   // Number format
   localparam int FMSU_WORD_W = 64;
   localparam int FMSU_SIGN_BIT = 63;
   localparam int FMSU_EXP_MSB = 62;
   localparam int FMSU_EXP_LSB = 55;
   localparam int FMSU_MANT_W = 56;
   localparam int FMSU_PRODUCT_VALUE_W = 112;
   localparam int FMSU_SGL_LOW = 32;
   localparam int FMSU_DBL_DROP = 53;
   localparam logic signed [10:0] FMSU_EXP_BIAS = 11'sh080;
   localparam logic signed [10:0] FMSU_EXP_MAX = 11'sh0FF;
   localparam logic signed [10:0] FMSU_EXP_ONE = 11'sh001;
   localparam logic signed [10:0] FMSU_LIMIT_SGL = 11'sh018;
   localparam logic signed [10:0] FMSU_LIMIT_DBL = 11'sh038;
   localparam int FMSU_ACC_N = 4;

   typedef enum logic {
      FMSU_OP_MULTIPLY,
      FMSU_OP_SPLIT
   } fmsu_op_t;

endpackage

// *** fmsu_top.sv ***
// Float multiply and split-multiply datapath with AHB-Lite register access
// Summary of operation
// - Split multiply, even destination: integer to next odd accumulator unless an operand exponent is zero, fraction to destination.
// - Split multiply, odd destination: integer part dropped, fraction to destination.
// - Significance limit is 24 bits in single, 56 bits in double.
// - Exponents are biased by octal 200.
// - Split overflow with trap enabled: chopped integer, exponent wrapped, fraction zero.
// - Split overflow with trap disabled: both results exact zero.
// - Product at least two to the limit minus one: chopped integer, fraction zero.
// - Product between one and limit: exact integer, rounded or chopped fraction.
// - Product below one: integer zero, fraction rounded or chopped.
// - Split underflow with trap enabled: integer zero, wrapped fraction, trap.
// - Split underflow with trap disabled: both results exact zero.
// - Split flags: carry clear, overflow on product overflow, zero/negative from destination.
// - Minus-zero source with its trap enabled traps before any accumulator changes.
// - Plain multiply with a zero exponent operand gives exact zero.
// - Plain product is 48 bits single, 59 bits double before rounding.
// - Chop select 0 rounds, 1 chops.
// - Plain overflow or underflow with trap disabled stores exact zero.
// - Plain overflow or underflow with trap enabled stores wrapped result and traps.
// - Plain flags: carry clear, overflow on overflow, zero/negative from result.
// - Minus zero only results with trapped overflow or underflow.
// - Precision select 0 is single, 1 is double.
//
// Added by the designer: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module fmsu_top
   import fmsu_pkg::*;
(
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp
);

   // Round or chop the top of a normalised mantissa to the active precision.
   // Bit 56 of the answer is the carry out of rounding.
   function automatic logic [FMSU_MANT_W:0] fmsu_round(input logic [FMSU_PRODUCT_VALUE_W-1:0] m, input logic dbl,
                                                       input logic chop);
      logic [FMSU_MANT_W:0] t;
      logic [FMSU_MANT_W:0] inc;
      t = {1'b0, m[FMSU_PRODUCT_VALUE_W-1:FMSU_PRODUCT_VALUE_W-FMSU_MANT_W]};
      inc = '0;
      if (dbl) begin
         inc[0] = ~chop & m[FMSU_PRODUCT_VALUE_W-FMSU_MANT_W-1];
      end else begin
         t[FMSU_SGL_LOW-1:0] = '0;
         inc[FMSU_SGL_LOW] = ~chop & m[FMSU_PRODUCT_VALUE_W-FMSU_MANT_W+FMSU_SGL_LOW-1];
      end
      return t + inc;
   endfunction

   // Leading zero count of a product-wide vector
   function automatic logic [6:0] fmsu_lzc(input logic [FMSU_PRODUCT_VALUE_W-1:0] v);
      logic [6:0] n;
      logic seen;
      n = '0;
      seen = 1'b0;
      for (int i = FMSU_PRODUCT_VALUE_W - 1; i >= 0; i--) begin
         if (!seen && !v[i]) begin
            n = n + 7'h01;
         end else begin
            seen = 1'b1;
         end
      end
      return n;
   endfunction

   // Assemble sign, biased exponent and mantissa with hidden bit dropped
   function automatic logic [FMSU_WORD_W-1:0] fmsu_pack(input logic s, input logic [7:0] e,
                                                        input logic [FMSU_MANT_W-1:0] m);
      return {s, e, m[FMSU_MANT_W-2:0]};
   endfunction

   // Biased exponent field; zero marks a zero value whatever the fraction holds
   function automatic logic [7:0] fmsu_exp(input logic [FMSU_WORD_W-1:0] v);
      return v[FMSU_EXP_MSB:FMSU_EXP_LSB];
   endfunction

   // Address phase capture
   logic dph_wr_reg;
   logic dph_rd_reg;
   logic rd_ready_reg;
   logic [7:0] dph_addr_reg;
   // Software-visible state
   logic [FMSU_MODE_W-1:0] mode_reg;
   logic [FMSU_CMD_W-1:0] cmd_reg;
   logic [FMSU_WORD_W-1:0] src_reg;
   logic [FMSU_ST_W-1:0] status_reg;
   logic [FMSU_WORD_W-1:0] acc_reg [FMSU_ACC_N];
   logic [31:0] hrdata_reg;

   logic addr_phase;
   logic wr_commit;
   logic start;
   logic [31:0] rd_mux;

   assign addr_phase = hsel & htrans[1] & hready;
   assign wr_commit = dph_wr_reg & hready;
   assign start = wr_commit && dph_addr_reg == FMSU_ADDR_CMD;

   // Reads take one wait state so a write in the previous data phase is seen
   assign hreadyout = ~(dph_rd_reg & ~rd_ready_reg);
   assign hrdata = hrdata_reg;
   assign hresp = 1'b0;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dph_wr_reg <= 1'b0;
         dph_rd_reg <= 1'b0;
         dph_addr_reg <= 8'h00;
      end else if (hready) begin
         dph_wr_reg <= addr_phase & hwrite;
         dph_rd_reg <= addr_phase & ~hwrite;
         dph_addr_reg <= {haddr[7:2], 2'b00};
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_ready_reg <= 1'b0;
         hrdata_reg <= 32'h00000000;
      end else if (dph_rd_reg && !rd_ready_reg) begin
         rd_ready_reg <= 1'b1;
         hrdata_reg <= rd_mux;
      end else begin
         rd_ready_reg <= 1'b0;
      end
   end

   always_comb begin
      rd_mux = 32'h00000000;
      if (dph_addr_reg >= FMSU_ADDR_ACC_BASE && dph_addr_reg <= FMSU_ADDR_ACC_LAST) begin
         rd_mux = dph_addr_reg[2] ? acc_reg[dph_addr_reg[4:3]][31:0] : acc_reg[dph_addr_reg[4:3]][63:32];
      end else begin
         unique case (dph_addr_reg)
            FMSU_ADDR_MODE: rd_mux = {{(32 - FMSU_MODE_W){1'b0}}, mode_reg};
            FMSU_ADDR_CMD: rd_mux = {{(32 - FMSU_CMD_W){1'b0}}, cmd_reg};
            FMSU_ADDR_SRC_HI: rd_mux = src_reg[63:32];
            FMSU_ADDR_SRC_LO: rd_mux = src_reg[31:0];
            FMSU_ADDR_STATUS: rd_mux = {{(32 - FMSU_ST_W){1'b0}}, status_reg};
            default: rd_mux = 32'h00000000;
         endcase
      end
   end

   // Execution datapath, evaluated on the command write itself
   fmsu_op_t op;
   logic [1:0] dest;
   logic dbl, chop, ovte, unte, uvte;
   logic [FMSU_WORD_W-1:0] a, b;
   logic [FMSU_MANT_W-1:0] msk, ma, mb;
   logic [FMSU_PRODUCT_VALUE_W-1:0] product_value, nm, fr, gn, topmask;
   logic signed [10:0] e, er, k, lim, eg;
   logic [FMSU_MANT_W:0] rr;
   logic [FMSU_MANT_W-1:0] mant;
   logic [6:0] lz;
   logic sp, zero_in, ovf, unf, trap_uv;
   logic [FMSU_WORD_W-1:0] res_g, res_n;
   logic wr_n;
   logic [FMSU_ST_W-1:0] st_next;

   always_comb begin
      op = hwdata[FMSU_CMD_SPLIT] ? FMSU_OP_SPLIT : FMSU_OP_MULTIPLY;
      dest = hwdata[FMSU_CMD_DEST_LSB +: 2];
      dbl = mode_reg[FMSU_MODE_PRECISION];
      chop = mode_reg[FMSU_MODE_CHOP];
      ovte = mode_reg[FMSU_MODE_OVF_TE];
      unte = mode_reg[FMSU_MODE_UNF_TE];
      uvte = mode_reg[FMSU_MODE_UV_TE];
      a = acc_reg[dest];
      b = src_reg;
      msk = dbl ? {FMSU_MANT_W{1'b1}} : {{(FMSU_MANT_W - FMSU_SGL_LOW){1'b1}}, {FMSU_SGL_LOW{1'b0}}};
      ma = {1'b1, a[54:0]} & msk;
      mb = {1'b1, b[54:0]} & msk;
      sp = a[FMSU_SIGN_BIT] ^ b[FMSU_SIGN_BIT];
      zero_in = fmsu_exp(a) == 8'h00 || fmsu_exp(b) == 8'h00;
      trap_uv = uvte && b[FMSU_SIGN_BIT] && fmsu_exp(b) == 8'h00;
      // Single gives 48 product bits; double keeps only the top 59
      product_value = ma * mb;
      if (dbl) begin
         product_value = product_value & {{(FMSU_PRODUCT_VALUE_W - FMSU_DBL_DROP){1'b1}}, {FMSU_DBL_DROP{1'b0}}};
      end
      e = $signed({3'b000, fmsu_exp(a)}) + $signed({3'b000, fmsu_exp(b)}) - FMSU_EXP_BIAS;
      if (!product_value[FMSU_PRODUCT_VALUE_W-1]) begin
         nm = product_value << 1;
         e = e - FMSU_EXP_ONE;
      end else begin
         nm = product_value;
      end
      k = e - FMSU_EXP_BIAS;
      lim = dbl ? FMSU_LIMIT_DBL : FMSU_LIMIT_SGL;
      rr = '0;
      mant = '0;
      er = e;
      eg = '0;
      lz = '0;
      fr = '0;
      gn = '0;
      topmask = '0;
      ovf = 1'b0;
      unf = 1'b0;
      res_g = '0;
      res_n = '0;
      wr_n = 1'b0;
      if (zero_in) begin
         res_g = '0;
      end else if (op == FMSU_OP_MULTIPLY) begin
         rr = fmsu_round(nm, dbl, chop);
         er = e + $signed({10'h000, rr[FMSU_MANT_W]});
         mant = rr[FMSU_MANT_W] ? rr[FMSU_MANT_W:1] : rr[FMSU_MANT_W-1:0];
         ovf = er > FMSU_EXP_MAX;
         unf = er < FMSU_EXP_ONE;
         // Trapped cases keep the exponent modulo 256, which may leave minus zero
         if ((ovf && !ovte) || (unf && !unte)) begin
            res_g = '0;
         end else begin
            res_g = fmsu_pack(sp, er[7:0], mant);
         end
      end else begin
         wr_n = ~dest[0];
         ovf = e > FMSU_EXP_MAX;
         unf = e < FMSU_EXP_ONE;
         if (ovf) begin
            if (ovte) begin
               rr = fmsu_round(nm, dbl, 1'b1);
               res_n = fmsu_pack(sp, e[7:0], rr[FMSU_MANT_W-1:0]);
            end else begin
               res_n = '0;
            end
            res_g = '0;
         end else if (k >= lim) begin
            rr = fmsu_round(nm, dbl, 1'b1);
            res_n = fmsu_pack(sp, e[7:0], rr[FMSU_MANT_W-1:0]);
            res_g = '0;
         end else if (k >= FMSU_EXP_ONE) begin
            topmask = ~({FMSU_PRODUCT_VALUE_W{1'b1}} >> k[6:0]);
            mant = nm[FMSU_PRODUCT_VALUE_W-1:FMSU_PRODUCT_VALUE_W-FMSU_MANT_W] & topmask[FMSU_PRODUCT_VALUE_W-1:FMSU_PRODUCT_VALUE_W-FMSU_MANT_W];
            res_n = fmsu_pack(sp, e[7:0], mant & msk);
            fr = nm << k[6:0];
            if (dbl) begin
               fr = fr;
            end else begin
               fr = fr & {{(FMSU_PRODUCT_VALUE_W - FMSU_MANT_W){1'b1}}, {FMSU_MANT_W{1'b0}}};
            end
            if (fr == '0) begin
               res_g = '0;
            end else begin
               lz = fmsu_lzc(fr);
               gn = fr << lz;
               rr = fmsu_round(gn, dbl, chop);
               // A carry out raises the fraction exponent by one; the sign stays the product's
               eg = FMSU_EXP_BIAS - $signed({4'h0, lz}) + $signed({10'h000, rr[FMSU_MANT_W]});
               mant = rr[FMSU_MANT_W] ? rr[FMSU_MANT_W:1] : rr[FMSU_MANT_W-1:0];
               res_g = fmsu_pack(sp, eg[7:0], mant);
            end
         end else begin
            res_n = '0;
            if (unf && !unte) begin
               res_g = '0;
            end else begin
               rr = fmsu_round(nm, dbl, chop);
               er = e + $signed({10'h000, rr[FMSU_MANT_W]});
               mant = rr[FMSU_MANT_W] ? rr[FMSU_MANT_W:1] : rr[FMSU_MANT_W-1:0];
               res_g = fmsu_pack(sp, er[7:0], mant);
            end
         end
      end
      st_next = '0;
      st_next[FMSU_ST_DONE] = 1'b1;
      st_next[FMSU_ST_TRAP_UV] = trap_uv;
      if (!trap_uv) begin
         st_next[FMSU_ST_CARRY] = 1'b0;
         st_next[FMSU_ST_OVF] = ovf;
         st_next[FMSU_ST_ZERO] = fmsu_exp(res_g) == 8'h00;
         st_next[FMSU_ST_NEG] = res_g[FMSU_SIGN_BIT];
         st_next[FMSU_ST_TRAP_OVF] = ovf & ovte;
         st_next[FMSU_ST_TRAP_UNF] = unf & unte;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_reg <= FMSU_MODE_RESET;
         src_reg <= '0;
      end else if (wr_commit) begin
         if (dph_addr_reg == FMSU_ADDR_MODE) begin
            mode_reg <= hwdata[FMSU_MODE_W-1:0];
         end
         if (dph_addr_reg == FMSU_ADDR_SRC_HI) begin
            src_reg[63:32] <= hwdata;
         end
         if (dph_addr_reg == FMSU_ADDR_SRC_LO) begin
            src_reg[31:0] <= hwdata;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cmd_reg <= '0;
         status_reg <= '0;
      end else if (start) begin
         cmd_reg <= hwdata[FMSU_CMD_W-1:0];
         status_reg <= st_next;
      end
   end

   // Accumulator file: software writes, or results of a command
   generate
      for (genvar i = 0; i < FMSU_ACC_N; i++) begin : g_acc
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               acc_reg[i] <= '0;
            end else if (start) begin
               if (!trap_uv) begin
                  if (dest == 2'(i)) begin
                     acc_reg[i] <= dbl ? res_g : {res_g[63:32], 32'h00000000};
                  end else if (wr_n && (dest | 2'b01) == 2'(i)) begin
                     acc_reg[i] <= dbl ? res_n : {res_n[63:32], 32'h00000000};
                  end
               end
            end else if (wr_commit && dph_addr_reg[7:3] == (FMSU_ADDR_ACC_BASE[7:3] + 5'(i))) begin
               if (dph_addr_reg[2]) begin
                  acc_reg[i][31:0] <= hwdata;
               end else begin
                  acc_reg[i][63:32] <= hwdata;
               end
            end
         end
      end
   endgenerate

   logic unused_ok;
   assign unused_ok = ^{hsize, haddr[31:8], haddr[1:0]};

endmodule // fmsu_top

// *** fmsu_chk.sv ***
// Bus-level assertions for the float multiply and split unit
`timescale 1ns/1ps
module fmsu_chk
   import fmsu_pkg::*;
(
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave side
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic hresp
);
   logic ph_rd_reg, ph_wr_reg, cmd_seen_reg;
   logic [7:0] ph_a_reg;
   logic [4:0] mode_reg;
   logic take, rd_now, st_rd, unmapped;
   assign take = hsel && htrans[1] && hready;
   assign rd_now = ph_rd_reg && hreadyout;
   assign st_rd = rd_now && ph_a_reg == FMSU_ADDR_STATUS;
   assign unmapped = (ph_a_reg > FMSU_ADDR_STATUS && ph_a_reg < FMSU_ADDR_ACC_BASE) || ph_a_reg > FMSU_ADDR_ACC_LAST;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph_rd_reg <= 1'b0;
         ph_wr_reg <= 1'b0;
         ph_a_reg <= 8'h00;
      end else if (hready) begin
         ph_rd_reg <= take && !hwrite;
         ph_wr_reg <= take && hwrite;
         ph_a_reg <= haddr[7:0];
      end
   end
   // Shadow of the mode bits, so reads can be judged without the design's state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_reg <= 5'h00;
         cmd_seen_reg <= 1'b0;
      end else if (ph_wr_reg && hready) begin
         if (ph_a_reg == FMSU_ADDR_MODE) mode_reg <= hwdata[4:0];
         if (ph_a_reg == FMSU_ADDR_CMD) cmd_seen_reg <= 1'b1;
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("bus response not okay");
   a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   a_write_nowait: assert property (take && hwrite |=> hreadyout)
      else $error("write was stalled");
   a_rdata_hold: assert property ($changed(hrdata) |-> $past(!hreadyout))
      else $error("read data moved outside a read");
   a_mode_readback: assert property (rd_now && ph_a_reg == FMSU_ADDR_MODE |-> hrdata == {27'h0, mode_reg})
      else $error("mode bits read back wrong");
   a_unmapped_zero: assert property (rd_now && unmapped |-> hrdata == 32'h0)
      else $error("unmapped read not zero");
   a_carry_clear: assert property (st_rd |-> !hrdata[FMSU_ST_CARRY])
      else $error("carry flag set");
   a_done_set: assert property (st_rd && cmd_seen_reg |-> hrdata[FMSU_ST_DONE])
      else $error("completion missing");
   a_uv_alone: assert property (st_rd && hrdata[FMSU_ST_TRAP_UV] |-> hrdata[7:0] == 8'h21)
      else $error("minus zero trap with other status");
   a_ovf_trap_flag: assert property (st_rd && hrdata[FMSU_ST_TRAP_OVF] |-> hrdata[2] && !hrdata[7])
      else $error("overflow trap without overflow flag");
   a_neg_zero_trap: assert property (rd_now && ph_a_reg >= FMSU_ADDR_ACC_BASE && !ph_a_reg[2]
      && hrdata[31:23] == 9'h100 |-> mode_reg[3:2] != 2'b00)
      else $error("minus zero stored without trap enable");
endmodule // fmsu_chk

// *** fmsu_seq_model.sv ***
// Sequencer model issuing single-word AHB-Lite transfers
`timescale 1ns/1ps
module fmsu_seq_model
   import fmsu_pkg::*;
(
   // Clock and answer
   input wire logic hclk,
   input wire logic hready,
   // Request
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata,
   // Bench hooks
   output logic rd_phase,
   output logic hang
);
   initial begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      rd_phase = 1'b0;
      hang = 1'b0;
   end
   task automatic wait_rdy();
      int n;
      n = 0;
      @(posedge hclk);
      while (hready !== 1'b1 && n < 16) begin
         n++;
         @(posedge hclk);
      end
      if (hready !== 1'b1) hang <= 1'b1;
   endtask
   // Operands, modes and command go out as whole words, held until taken
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= wr;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'b00;
      haddr <= ~{24'h0, a};
      if (wr) hwdata <= d;
      else rd_phase <= 1'b1;
      wait_rdy();
      // Released data is scrambled so stale values never look valid
      if (wr) hwdata <= ~d;
      else rd_phase <= 1'b0;
   endtask
endmodule // fmsu_seq_model

// *** fmsu_top_tb.sv ***
// Self-checking bench for the float multiply and split unit
`timescale 1ns/1ps
module fmsu_top_tb;
   import fmsu_pkg::*;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, rd_phase, hang;
   logic [31:0] haddr, hwdata, hrdata, p_val, r_val;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] exp_q[$];
   int error_cnt = 0;
   int tests_run = 0;
   int seed = 32'h493a;
   assign hready = hreadyout;
   initial begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end
   fmsu_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));
   fmsu_seq_model m (.hclk(hclk), .hready(hready), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .rd_phase(rd_phase), .hang(hang));
   task automatic complete_run();
      if (error_cnt == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   always @(posedge hclk) begin
      if (rd_phase === 1'b1 && hreadyout === 1'b1) chk(exp_q.pop_front(), hrdata);
      if (hang === 1'b1) begin
         error_cnt++;
         complete_run();
      end
   end
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      m.xfer(1'b0, a, 32'h0);
   endtask
   task automatic run_case(input logic [4:0] md, input logic [2:0] cmd, input logic [31:0] a, s, ed, el, eo, eol,
      input int ko, input logic [7:0] st);
      logic [7:0] d, o;
      d = FMSU_ADDR_ACC_BASE + {3'h0, cmd[1:0], 3'h0};
      o = FMSU_ADDR_ACC_BASE + {3'h0, cmd[1:0] ^ 2'h1, 3'h0};
      // Random preset keeps a nonzero exponent so it never reads as minus zero
      p_val = $random(seed) | 32'h40000000;
      m.xfer(1'b1, FMSU_ADDR_MODE, {27'h0, md});
      m.xfer(1'b1, d, a);
      m.xfer(1'b1, d + 8'h04, 32'h0);
      m.xfer(1'b1, o, p_val);
      m.xfer(1'b1, FMSU_ADDR_SRC_HI, s);
      m.xfer(1'b1, FMSU_ADDR_SRC_LO, 32'h0);
      m.xfer(1'b1, FMSU_ADDR_CMD, {29'h0, cmd});
      rd(d, ed);
      rd(d + 8'h04, el);
      rd(FMSU_ADDR_STATUS, {24'h0, st});
      rd(o, ko ? p_val : eo);
      if (!ko) rd(o + 8'h04, eol);
   endtask
   initial begin
      hresetn = 1'b0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      rd(FMSU_ADDR_STATUS, 32'h0);
      rd(FMSU_ADDR_ACC_BASE, 32'h0);
      run_case(5'h00, 3'h0, 32'h41000000, 32'h41400000, 32'h41C00000, 32'h0, 32'h0, 32'h0, 1, 8'h01);
      run_case(5'h00, 3'h2, 32'h00400000, 32'h41400000, 32'h0, 32'h0, 32'h0, 32'h0, 1, 8'h09);
      run_case(5'h00, 3'h3, 32'h40C00001, 32'h41400000, 32'h41900001, 32'h0, 32'h0, 32'h0, 1, 8'h01);
      run_case(5'h02, 3'h3, 32'h40C00001, 32'h41400000, 32'h41900000, 32'h0, 32'h0, 32'h0, 1, 8'h01);
      run_case(5'h01, 3'h1, 32'h40C00001, 32'h41400000, 32'h41900000, 32'hC0000000, 32'h0, 32'h0,
         1, 8'h01);
      run_case(5'h00, 3'h0, 32'h7F800000, 32'h41800000, 32'h0, 32'h0, 32'h0, 32'h0, 1, 8'h0D);
      run_case(5'h04, 3'h0, 32'h7F800000, 32'h41800000, 32'h00800000, 32'h0, 32'h0, 32'h0, 1, 8'h45);
      run_case(5'h00, 3'h0, 32'h00800000, 32'h3F800000, 32'h0, 32'h0, 32'h0, 32'h0, 1, 8'h09);
      run_case(5'h08, 3'h0, 32'h00800000, 32'h3F800000, 32'h7F800000, 32'h0, 32'h0, 32'h0, 1, 8'h81);
      run_case(5'h10, 3'h0, 32'h41000000, 32'h80000000, 32'h41000000, 32'h0, 32'h0, 32'h0, 1, 8'h21);
      run_case(5'h04, 3'h0, 32'hFF800000, 32'h41400000, 32'h80400000, 32'h0, 32'h0, 32'h0, 1, 8'h5D);
      run_case(5'h00, 3'h4, 32'h41200000, 32'h41400000, 32'h40000000, 32'h0, 32'h41E00000, 32'h0, 0, 8'h01);
      run_case(5'h00, 3'h7, 32'h41200000, 32'h41400000, 32'h40000000, 32'h0, 32'h0, 32'h0, 1, 8'h01);
      run_case(5'h00, 3'h4, 32'h40000000, 32'h40000000, 32'h3F800000, 32'h0, 32'h0, 32'h0, 0, 8'h01);
      run_case(5'h00, 3'h4, 32'h4B800003, 32'h41A00000, 32'h0, 32'h0, 32'h4CA00003, 32'h0,
         0, 8'h09);
      run_case(5'h01, 3'h4, 32'h4B800003, 32'h41A00000, 32'h40000000, 32'h0, 32'h4CA00003, 32'h80000000,
         0, 8'h01);
      run_case(5'h00, 3'h4, 32'h7F800000, 32'h41800000, 32'h0, 32'h0, 32'h0, 32'h0, 0, 8'h0D);
      run_case(5'h04, 3'h4, 32'h7F800000, 32'h41800000, 32'h0, 32'h0, 32'h00800000, 32'h0, 0, 8'h4D);
      run_case(5'h08, 3'h4, 32'h00800000, 32'h3F800000, 32'h7F800000, 32'h0, 32'h0, 32'h0, 0, 8'h81);
      run_case(5'h00, 3'h4, 32'h00800000, 32'h3F800000, 32'h0, 32'h0, 32'h0, 32'h0, 0, 8'h09);
      r_val = $random(seed);
      m.xfer(1'b1, FMSU_ADDR_STATUS, r_val);
      rd(FMSU_ADDR_STATUS, 32'h09);
      m.xfer(1'b1, 8'h14, r_val);
      rd(8'h14, 32'h0);
      rd(8'h40, 32'h0);
      m.xfer(1'b1, FMSU_ADDR_MODE, r_val);
      rd(FMSU_ADDR_MODE, {27'h0, r_val[4:0]});
      repeat (2) @(posedge hclk);
      complete_run();
   end
endmodule // fmsu_top_tb
bind fmsu_top fmsu_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
   .hresp(hresp));
